// ==== hw/pcf_pkg.sv ====
// Constants for the PLL configuration and status flag block
package pcf_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0] IDX_MULT    = 10'h034;
    localparam logic [9:0] IDX_REF_DIVIDER  = 10'h035;
    localparam logic [9:0] IDX_OUTPUT_DIVIDER = 10'h036;
    localparam logic [9:0] IDX_FLAGS   = 10'h037;
    localparam logic [9:0] IDX_IRQEN   = 10'h038;
    localparam logic [9:0] IDX_CLKSEL  = 10'h039;
    localparam logic [9:0] IDX_OSCCTL  = 10'h2FA;
    localparam logic [9:0] IDX_GUARD   = 10'h2FB;
    localparam int         ADDR_W      = 12;

    // Field positions
    localparam int MULT_LSB     = 0;
    localparam int MULT_W       = 6;
    localparam int GAIN_LSB     = 6;
    localparam int REF_DIVIDER_LSB   = 0;
    localparam int REF_DIVIDER_W     = 4;
    localparam int FILT_LSB     = 6;
    localparam int OUTPUT_DIVIDER_LSB  = 0;
    localparam int OUTPUT_DIVIDER_W    = 5;
    localparam int FLG_TIMEOUT  = 7;
    localparam int FLG_POWERON  = 6;
    localparam int FLG_BROWNOUT = 5;
    localparam int FLG_LOCKCHG  = 4;
    localparam int FLG_LOCK     = 3;
    localparam int FLG_BADADDR  = 2;
    localparam int FLG_OSCCHG   = 1;
    localparam int FLG_OSCOK    = 0;
    localparam int CLKSEL_BIT   = 7;
    localparam int OSCEN_BIT    = 7;
    localparam int GUARD_BIT    = 0;

    // Reset values
    localparam logic [7:0] RST_MULT    = 8'h00;
    localparam logic [7:0] RST_REF_DIVIDER  = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DIVIDER = 8'h00;
    localparam logic [7:0] RST_IRQEN   = 8'h00;
    localparam logic       RST_CLKSEL  = 1'b1;
    localparam logic       RST_OSCEN   = 1'b0;
    localparam logic       RST_GUARD   = 1'b0;

    // Fixed ratios and masks
    localparam logic [5:0] UNLOCK_DIV  = 6'h04;
    localparam logic [1:0] FILT_LOW    = 2'h0;
    localparam logic [7:0] IRQ_SRC_MSK = 8'h92;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hw/pcf_top.sv ====
// PLL configuration registers, clock/reset status flags and AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcf_top
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        por_n_i,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [11:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // Events and analog status
    input  wire logic        pll_lock_i,
    input  wire logic        osc_qualified_i,
    input  wire logic        periodic_timeout_i,
    input  wire logic        brownout_event_i,
    input  wire logic        bad_address_event_i,
    input  wire logic        full_stop_i,
    // PLL settings
    output logic [5:0]       loop_multiplier_o,
    output logic [1:0]       vco_gain_range_o,
    output logic [3:0]       ref_divider_o,
    output logic [1:0]       filter_range_o,
    output logic [4:0]       output_divider_o,
    output logic             ext_osc_enable_o,
    output logic             loop_clock_select_o,
    output logic [7:0]       vco_ratio_o,
    output logic [4:0]       ref_ratio_o,
    output logic [5:0]       out_ratio_o,
    output logic             pll_restart_o,
    output logic             irq_o
);
    // Register state
    logic [7:0] mult_q, ref_divider_q, output_divider_q, irqen_q;
    logic       clksel_q, oscen_q, guard_q;
    logic       tmo_q, por_q, lvr_q, lkchg_q, lock_q, ila_q, oschg_q, oscok_q;
    logic       lock_d, oscok_d, clksel_d;

    // Bus channel state
    logic        aw_full_q, w_full_q;
    logic [11:0] aw_addr_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Synchronisers for the analog status inputs
    logic [1:0] lock_sync_q, osc_sync_q;
    logic       lock_last_q, osc_last_q;

    logic sys_rst;
    assign sys_rst = !rst_n_i || !por_n_i;

    // Write decode
    wire        wr_fire   = aw_full_q && w_full_q && !bvalid_q;
    wire [9:0]  wr_idx    = aw_addr_q[11:2];
    wire        wr_byte   = wr_fire && w_lane_q;
    wire        wr_mult   = wr_byte && wr_idx == pcf_pkg::IDX_MULT;
    wire        wr_ref_divider = wr_byte && wr_idx == pcf_pkg::IDX_REF_DIVIDER;
    wire        wr_post   = wr_byte && wr_idx == pcf_pkg::IDX_OUTPUT_DIVIDER;
    wire        wr_flags  = wr_byte && wr_idx == pcf_pkg::IDX_FLAGS;
    wire        wr_irqen  = wr_byte && wr_idx == pcf_pkg::IDX_IRQEN;
    wire        wr_clksel = wr_byte && wr_idx == pcf_pkg::IDX_CLKSEL;
    wire        wr_oscctl = wr_byte && wr_idx == pcf_pkg::IDX_OSCCTL;
    wire        wr_guard  = wr_byte && wr_idx == pcf_pkg::IDX_GUARD;
    wire        cfg_open  = !guard_q && clksel_q;
    wire        mult_take = wr_mult && cfg_open;
    wire        ref_take  = wr_ref_divider && cfg_open;
    wire        post_take = wr_post && clksel_q;
    wire        loop_clr  = mult_take || ref_take;
    wire [7:0]  w1c       = wr_flags ? w_data_q : 8'h00;

    function automatic logic map_hit(input logic [9:0] idx);
        map_hit = idx == pcf_pkg::IDX_MULT   || idx == pcf_pkg::IDX_REF_DIVIDER ||
                  idx == pcf_pkg::IDX_OUTPUT_DIVIDER|| idx == pcf_pkg::IDX_FLAGS  ||
                  idx == pcf_pkg::IDX_IRQEN  || idx == pcf_pkg::IDX_CLKSEL ||
                  idx == pcf_pkg::IDX_OSCCTL || idx == pcf_pkg::IDX_GUARD;
    endfunction

    // Channel handshakes
    assign s_axi_awready_o = !aw_full_q;
    assign s_axi_wready_o  = !w_full_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rresp_o   = rresp_q;
    assign s_axi_rdata_o   = rdata_q;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end
        else if (s_axi_awvalid_i && !aw_full_q)
        begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            w_full_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end
        else if (s_axi_wvalid_i && !w_full_q)
        begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i[7:0];
            w_lane_q <= s_axi_wstrb_i[0];
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            w_full_q <= 1'b0;
        end
    end

    // Blocked writes still answer OKAY; only an unmapped address errs
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= pcf_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= map_hit(wr_idx) ? pcf_pkg::RESP_OKAY : pcf_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_i)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Read mux
    wire [9:0] rd_idx = s_axi_araddr_i[11:2];
    wire [7:0] flags_rd = {tmo_q, por_q, lvr_q, lkchg_q, lock_q, ila_q, oschg_q, oscok_q};
    logic [7:0] rd_byte;
    assign rd_byte =
        rd_idx == pcf_pkg::IDX_MULT    ? mult_q :
        rd_idx == pcf_pkg::IDX_REF_DIVIDER  ? ref_divider_q :
        rd_idx == pcf_pkg::IDX_OUTPUT_DIVIDER ? output_divider_q :
        rd_idx == pcf_pkg::IDX_FLAGS   ? flags_rd :
        rd_idx == pcf_pkg::IDX_IRQEN   ? irqen_q :
        rd_idx == pcf_pkg::IDX_CLKSEL  ? 8'(clksel_q) << pcf_pkg::CLKSEL_BIT :
        rd_idx == pcf_pkg::IDX_OSCCTL  ? 8'(oscen_q) << pcf_pkg::OSCEN_BIT :
        rd_idx == pcf_pkg::IDX_GUARD   ? 8'(guard_q) << pcf_pkg::GUARD_BIT : 8'h00;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= pcf_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_i && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= map_hit(rd_idx) ? pcf_pkg::RESP_OKAY : pcf_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            mult_q    <= pcf_pkg::RST_MULT;
            ref_divider_q  <= pcf_pkg::RST_REF_DIVIDER;
            output_divider_q <= pcf_pkg::RST_OUTPUT_DIVIDER;
            irqen_q   <= pcf_pkg::RST_IRQEN;
            oscen_q   <= pcf_pkg::RST_OSCEN;
            guard_q   <= pcf_pkg::RST_GUARD;
        end
        else
        begin
            if (mult_take)
                mult_q <= w_data_q;
            if (ref_take)
                ref_divider_q <= w_data_q & 8'hCF;
            if (post_take)
                output_divider_q <= w_data_q & 8'h1F;
            if (wr_irqen)
                irqen_q <= w_data_q & pcf_pkg::IRQ_SRC_MSK;
            if (wr_oscctl && !guard_q)
                oscen_q <= w_data_q[pcf_pkg::OSCEN_BIT];
            if (wr_guard)
                guard_q <= w_data_q[pcf_pkg::GUARD_BIT];
        end
    end

    // PLL select may drop only with a qualified oscillator; losing it forces the PLL
    always_comb
    begin
        clksel_d = clksel_q;
        if (wr_clksel && !guard_q)
            clksel_d = w_data_q[pcf_pkg::CLKSEL_BIT];
        if (!oscok_d)
            clksel_d = 1'b1;
    end

    // Analog status crossing: first stage feeds only the second
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            lock_sync_q <= 2'b00;
            osc_sync_q  <= 2'b00;
            lock_last_q <= 1'b0;
            osc_last_q  <= 1'b0;
        end
        else
        begin
            lock_sync_q <= {lock_sync_q[0], pll_lock_i};
            osc_sync_q  <= {osc_sync_q[0], osc_qualified_i};
            lock_last_q <= lock_sync_q[1];
            osc_last_q  <= osc_sync_q[1];
        end
    end

    wire lock_rise = lock_sync_q[1] && !lock_last_q;
    wire lock_fall = !lock_sync_q[1] && lock_last_q;
    wire osc_rise  = osc_sync_q[1] && !osc_last_q;
    wire osc_fall  = !osc_sync_q[1] && osc_last_q;

    // Status bits follow input edges so a cleared bit waits for a fresh lock/qualify
    always_comb
    begin
        lock_d = lock_q;
        if (lock_rise)
            lock_d = 1'b1;
        if (lock_fall || loop_clr)
            lock_d = 1'b0;
        oscok_d = oscok_q;
        if (osc_rise)
            oscok_d = 1'b1;
        if (osc_fall || loop_clr || full_stop_i)
            oscok_d = 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            lock_q   <= 1'b0;
            oscok_q  <= 1'b0;
            clksel_q <= pcf_pkg::RST_CLKSEL;
        end
        else
        begin
            lock_q   <= lock_d;
            oscok_q  <= oscok_d;
            clksel_q <= clksel_d;
        end
    end

    // Event flags: set term ORed last so it wins over a write-one clear
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            tmo_q   <= 1'b0;
            lkchg_q <= 1'b0;
            oschg_q <= 1'b0;
        end
        else
        begin
            tmo_q   <= (tmo_q && !w1c[pcf_pkg::FLG_TIMEOUT]) || periodic_timeout_i;
            lkchg_q <= (lkchg_q && !w1c[pcf_pkg::FLG_LOCKCHG])
                       || (lock_d != lock_q);
            oschg_q <= (oschg_q && !w1c[pcf_pkg::FLG_OSCCHG])
                       || (oscok_d != oscok_q);
        end
    end

    // Reset-cause flags see only power-on reset, never system reset
    always_ff @(posedge core_clk_i)
    begin
        if (!por_n_i)
        begin
            por_q <= 1'b1;
            lvr_q <= 1'b1;
            ila_q <= 1'b0;
        end
        else
        begin
            por_q <= por_q && !w1c[pcf_pkg::FLG_POWERON];
            lvr_q <= (lvr_q && !w1c[pcf_pkg::FLG_BROWNOUT]) || brownout_event_i;
            ila_q <= (ila_q && !w1c[pcf_pkg::FLG_BADADDR]) || bad_address_event_i;
        end
    end

    // Derived ratios for the analog loop, registered
    wire [7:0] vco_ratio_d = {mult_q[pcf_pkg::MULT_LSB +: pcf_pkg::MULT_W] + 6'h01 == 6'h00,
                              6'(mult_q[pcf_pkg::MULT_LSB +: pcf_pkg::MULT_W] + 6'h01), 1'b0};
    wire [4:0] ref_divider_p1   = {1'b0, ref_divider_q[pcf_pkg::REF_DIVIDER_LSB +: pcf_pkg::REF_DIVIDER_W]} + 5'h01;
    wire [5:0] output_divider_p1  = {1'b0, output_divider_q[pcf_pkg::OUTPUT_DIVIDER_LSB +: pcf_pkg::OUTPUT_DIVIDER_W]}
                             + 6'h01;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst)
        begin
            vco_ratio_o    <= 8'h02;
            ref_ratio_o    <= 5'h01;
            out_ratio_o    <= pcf_pkg::UNLOCK_DIV;
            filter_range_o <= pcf_pkg::FILT_LOW;
            pll_restart_o  <= 1'b0;
            irq_o          <= 1'b0;
        end
        else
        begin
            vco_ratio_o    <= vco_ratio_d;
            ref_ratio_o    <= oscen_q ? ref_divider_p1 : 5'h01;
            out_ratio_o    <= lock_q ? output_divider_p1 : pcf_pkg::UNLOCK_DIV;
            filter_range_o <= oscen_q ? ref_divider_q[pcf_pkg::FILT_LSB +: 2]
                                      : pcf_pkg::FILT_LOW;
            pll_restart_o  <= loop_clr;
            irq_o          <= |(flags_rd & irqen_q & pcf_pkg::IRQ_SRC_MSK);
        end
    end

    // Raw fields; gain and filter codes are software's responsibility
    assign loop_multiplier_o   = mult_q[pcf_pkg::MULT_LSB +: pcf_pkg::MULT_W];
    assign vco_gain_range_o    = mult_q[pcf_pkg::GAIN_LSB +: 2];
    assign ref_divider_o       = ref_divider_q[pcf_pkg::REF_DIVIDER_LSB +: pcf_pkg::REF_DIVIDER_W];
    assign output_divider_o    = output_divider_q[pcf_pkg::OUTPUT_DIVIDER_LSB +: pcf_pkg::OUTPUT_DIVIDER_W];
    assign ext_osc_enable_o    = oscen_q;
    assign loop_clock_select_o = clksel_q;
endmodule
`default_nettype wire

// ==== tb/pcf_props.sv ====
// Assertion checker for the PLL configuration and status flag block
`timescale 1ns/1ps
`default_nettype none
module pcf_props
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       por_n_i,
    input  wire logic       s_axi_awvalid_i,
    input  wire logic       s_axi_awready_o,
    input  wire logic       s_axi_wvalid_i,
    input  wire logic       s_axi_wready_o,
    input  wire logic       s_axi_bvalid_o,
    input  wire logic       s_axi_bready_i,
    input  wire logic [5:0] loop_multiplier_o,
    input  wire logic [3:0] ref_divider_o,
    input  wire logic [4:0] output_divider_o,
    input  wire logic       ext_osc_enable_o,
    input  wire logic       loop_clock_select_o,
    input  wire logic [7:0] vco_ratio_o,
    input  wire logic [4:0] ref_ratio_o,
    input  wire logic [5:0] out_ratio_o,
    input  wire logic [1:0] filter_range_o,
    input  wire logic       pll_restart_o
);
    // One quiet edge after any reset, so $past never reaches into pre-reset values
    logic rst_ok_q;
    always_ff @(posedge core_clk_i) rst_ok_q <= rst_n_i && por_n_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i || !por_n_i || !rst_ok_q);
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_b_done;
        s_axi_bvalid_o && s_axi_bready_i;
    endsequence
    property p_vco;
        vco_ratio_o == ({2'h0, $past(loop_multiplier_o)} + 8'h01) << 1;
    endproperty
    property p_ref;
        ref_ratio_o == ($past(ext_osc_enable_o) ? {1'h0, $past(ref_divider_o)} + 5'h01 : 5'h01);
    endproperty
    property p_filt;
        !$past(ext_osc_enable_o) |-> filter_range_o == 2'h0;
    endproperty
    property p_out;
        out_ratio_o == 6'h04 || out_ratio_o == {1'h0, $past(output_divider_o)} + 6'h01;
    endproperty
    property p_mult_guard;
        !$stable(loop_multiplier_o) |-> $past(loop_clock_select_o);
    endproperty
    property p_post_guard;
        !$stable(output_divider_o) |-> $past(loop_clock_select_o);
    endproperty
    property p_restart_cause;
        pll_restart_o |-> s_axi_bvalid_o || $past(s_axi_bvalid_o);
    endproperty
    property p_restart_pulse;
        pll_restart_o |=> !pll_restart_o;
    endproperty
    property p_b_answer;
        s_wr_take |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    property p_b_clear;
        s_b_done |=> !s_axi_bvalid_o;
    endproperty
    a_vco: assert property (p_vco) else $error("vco ratio wrong");
    a_ref: assert property (p_ref) else $error("reference ratio wrong");
    a_filt: assert property (p_filt) else $error("filter not fixed low");
    a_out: assert property (p_out) else $error("output ratio wrong");
    a_mult_guard: assert property (p_mult_guard) else $error("multiplier changed");
    a_post_guard: assert property (p_post_guard) else $error("divider changed");
    a_restart_cause: assert property (p_restart_cause) else $error("restart without write");
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
    a_b_answer: assert property (p_b_answer) else $error("no write response");
    a_b_clear: assert property (p_b_clear) else $error("response not cleared");
endmodule
bind pcf_top pcf_props pcf_props_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .loop_multiplier_o(loop_multiplier_o), .ref_divider_o(ref_divider_o),
    .output_divider_o(output_divider_o), .ext_osc_enable_o(ext_osc_enable_o),
    .loop_clock_select_o(loop_clock_select_o), .vco_ratio_o(vco_ratio_o),
    .ref_ratio_o(ref_ratio_o), .out_ratio_o(out_ratio_o), .filter_range_o(filter_range_o),
    .pll_restart_o(pll_restart_o));
`default_nettype wire

// ==== tb/pcf_top_tb.sv ====
// Self-checking testbench for the PLL configuration and status flag block
`timescale 1ns/1ps
`default_nettype none
module pcf_top_tb;
    typedef struct packed {logic [9:0] idx; logic [7:0] wd; logic [7:0] rexp; logic [1:0] rsp;} pcf_row_t;
    logic        clk, rst_n, por_n, awvalid, wvalid, bready, arvalid, rready, lock, oscq;
    logic        awready, wready, bvalid, arready, rvalid, oscen, clksel, restart, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, gain, filt;
    logic [3:0]  ev, ref_divider;
    logic [5:0]  mult, outr;
    logic [4:0]  output_divider, refr;
    logic [7:0]  vco;
    pcf_row_t    rows [5];
    int          err_total, total_checks;

    pcf_top pcf_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pll_lock_i(lock),
        .osc_qualified_i(oscq), .periodic_timeout_i(ev[0]), .brownout_event_i(ev[1]),
        .bad_address_event_i(ev[2]), .full_stop_i(ev[3]), .loop_multiplier_o(mult),
        .vco_gain_range_o(gain), .ref_divider_o(ref_divider), .filter_range_o(filt),
        .output_divider_o(output_divider), .ext_osc_enable_o(oscen), .loop_clock_select_o(clksel),
        .vco_ratio_o(vco), .ref_ratio_o(refr), .out_ratio_o(outr), .pll_restart_o(restart),
        .irq_o(irq));

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'h1;
        @(posedge clk);
        ev[b] <= 1'h0;
    endtask

    // Address and data go out together; each is dropped on its own ready
    task automatic wr_reg(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            n++;
        end
        while (!bvalid && n < 64);
        bready <= 1'h0;
        if (n >= 64)
        begin
            err_total++;
            finish_test();
        end
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd_reg(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            n++;
        end
        while (!rvalid && n < 64);
        rready <= 1'h0;
        if (n >= 64)
        begin
            err_total++;
            finish_test();
        end
        chk({30'h0, rresp}, {30'h0, er});
        chk(rdata, {24'h000000, e});
    endtask

    initial
    begin
        {rst_n, por_n, awvalid, wvalid, bready, arvalid, rready, lock, oscq} = '0;
        {awaddr, araddr, wdata, ev} = '0;
        err_total = 0;
        total_checks = 0;
        rows[0] = '{pcf_pkg::IDX_MULT, 8'hC7, 8'hC7, pcf_pkg::RESP_OKAY};
        rows[1] = '{pcf_pkg::IDX_REF_DIVIDER, 8'hFF, 8'hCF, pcf_pkg::RESP_OKAY};
        rows[2] = '{pcf_pkg::IDX_OUTPUT_DIVIDER, 8'hFF, 8'h1F, pcf_pkg::RESP_OKAY};
        rows[3] = '{pcf_pkg::IDX_IRQEN, 8'hFF, 8'h92, pcf_pkg::RESP_OKAY};
        rows[4] = '{10'h03A, 8'hFF, 8'h00, pcf_pkg::RESP_SLVERR};
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        por_n <= 1'h1;
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h60, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_MULT, 8'h00, pcf_pkg::RESP_OKAY);
        pulse(2);
        cyc(2);
        @(posedge clk);
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h64, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'h00, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h64, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'hFF, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h00, pcf_pkg::RESP_OKAY);
        pulse(1);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h20, pcf_pkg::RESP_OKAY);
        pulse(2);
        @(posedge clk);
        por_n <= 1'h0;
        @(posedge clk);
        por_n <= 1'h1;
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h60, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'h60, pcf_pkg::RESP_OKAY);
        foreach (rows[i])
        begin
            wr_reg(rows[i].idx, rows[i].wd, rows[i].rsp);
            rd_reg(rows[i].idx, rows[i].rexp, rows[i].rsp);
        end
        chk({24'h0, vco}, 32'h10);
        chk({26'h0, outr}, 32'h4);
        chk({27'h0, refr}, 32'h1);
        chk({30'h0, filt}, 32'h0);
        wr_reg(pcf_pkg::IDX_OSCCTL, 8'h80, pcf_pkg::RESP_OKAY);
        cyc(2);
        chk({31'h0, oscen}, 32'h1);
        chk({27'h0, refr}, 32'h10);
        chk({30'h0, filt}, 32'h3);
        wr_reg(pcf_pkg::IDX_GUARD, 8'h01, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_MULT, 8'h05, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_MULT, 8'hC7, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_GUARD, 8'h00, pcf_pkg::RESP_OKAY);
        oscq <= 1'h1;
        cyc(5);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h03, pcf_pkg::RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'h02, pcf_pkg::RESP_OKAY);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        // Clock select may drop only while the oscillator is qualified
        wr_reg(pcf_pkg::IDX_CLKSEL, 8'h00, pcf_pkg::RESP_OKAY);
        chk({31'h0, clksel}, 32'h0);
        wr_reg(pcf_pkg::IDX_OUTPUT_DIVIDER, 8'h03, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_OUTPUT_DIVIDER, 8'h1F, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_MULT, 8'h05, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_MULT, 8'hC7, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_CLKSEL, 8'h80, pcf_pkg::RESP_OKAY);
        wr_reg(pcf_pkg::IDX_MULT, 8'h05, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h02, pcf_pkg::RESP_OKAY);
        chk({24'h0, vco}, 32'h0C);
        chk({26'h0, mult}, 32'h5);
        chk({30'h0, gain}, 32'h0);
        lock <= 1'h1;
        cyc(5);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h1A, pcf_pkg::RESP_OKAY);
        chk({26'h0, outr}, 32'h20);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'h1B, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h08, pcf_pkg::RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        pulse(0);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h88, pcf_pkg::RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr_reg(pcf_pkg::IDX_IRQEN, 8'h00, pcf_pkg::RESP_OKAY);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        wr_reg(pcf_pkg::IDX_FLAGS, 8'h80, pcf_pkg::RESP_OKAY);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h08, pcf_pkg::RESP_OKAY);
        oscq <= 1'h0;
        cyc(5);
        oscq <= 1'h1;
        cyc(5);
        pulse(3);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h0A, pcf_pkg::RESP_OKAY);
        lock <= 1'h0;
        cyc(5);
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h12, pcf_pkg::RESP_OKAY);
        chk({26'h0, outr}, 32'h4);
        // Brownout event lands on the very edge that applies the write-one clear
        fork
            wr_reg(pcf_pkg::IDX_FLAGS, 8'h20, pcf_pkg::RESP_OKAY);
            begin
                cyc(2);
                ev[1] <= 1'h1;
                cyc(1);
                ev[1] <= 1'h0;
            end
        join
        rd_reg(pcf_pkg::IDX_FLAGS, 8'h32, pcf_pkg::RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire
